// file: src/octal_adc_serial_readout.sv
// Summary of operation
// [R1] Start input high means acquisition on all channels
// [R2] Start input low converts and starts data output
// [R3] Start input ignores the I/O standard select
// [R4] Single rate: shift one bit per falling edge
// [R5] Double rate: shift one bit per clock edge
// [R6] Echoed clock is delayed copy of shift clock
// [R7] Receiver ties echo disable high to switch off
// [R8] Select: ground CMOS, high LVDS, float low-power LVDS
// [R9] CMOS: eight outputs, own channel, MSB first
// [R10] CMOS single rate: 16 edges per channel
// [R11] CMOS double rate: 16 edges per channel
// [R12] Extra clocks rotate following channels, wrap eight
// [R13] LVDS first pair: channel 1 then 2
// [R14] LVDS: 32 edges single, 32 double rate
// [R15] Other pairs carry 3-4, 5-6, 7-8, lower first
// [R16] Results are two's complement
// [R17] Receiver captures on echoed clock, same edges
`timescale 1ns/10ps
`default_nettype none

module octal_adc_serial_readout (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [31:0] read_data,
    input wire logic conversion_start_n,
    input wire logic shift_clock,
    input wire logic data_rate_select,
    input wire logic echo_clock_disable,
    input wire logic io_select_high,
    input wire logic io_select_float,
    output logic echoed_shift_clock,
    output logic serial_out_ch1,
    output logic serial_out_ch2,
    output logic serial_out_ch3,
    output logic serial_out_ch4,
    output logic serial_out_ch5,
    output logic serial_out_ch6,
    output logic serial_out_ch7,
    output logic serial_out_ch8,
    output logic serial_out_oe,
    output logic diff_out_pair_ch1_2_p,
    output logic diff_out_pair_ch1_2_n,
    output logic diff_out_pair_ch3_4_p,
    output logic diff_out_pair_ch3_4_n,
    output logic diff_out_pair_ch5_6_p,
    output logic diff_out_pair_ch5_6_n,
    output logic diff_out_pair_ch7_8_p,
    output logic diff_out_pair_ch7_8_n,
    output logic diff_out_oe
);

    // ------------------------------------------------------------------
    // System clock domain: pin synchronisers
    // ------------------------------------------------------------------
    logic cnv_meta_r;
    logic cnv_sync_r;
    logic cnv_prev_r;
    adc_readout_pkg::strap_t strap_meta_r;
    adc_readout_pkg::strap_t strap_sync_r;
    adc_readout_pkg::strap_t strap_pins;

    assign strap_pins = '{sel_float: io_select_float, sel_high: io_select_high,
                          echo_off: echo_clock_disable, ddr: data_rate_select};

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnv_meta_r <= 1'b1;
            cnv_sync_r <= 1'b1;
            cnv_prev_r <= 1'b1;
        end else begin
            cnv_meta_r <= conversion_start_n;
            cnv_sync_r <= cnv_meta_r;
            cnv_prev_r <= cnv_sync_r;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            strap_meta_r <= adc_readout_pkg::STRAP_RST;
            strap_sync_r <= adc_readout_pkg::STRAP_RST;
        end else begin
            strap_meta_r <= strap_pins;
            strap_sync_r <= strap_meta_r;
        end
    end

    // Conversion start is a plain pin, whatever the output standard
    wire cnv_fall = cnv_prev_r & ~cnv_sync_r; // [R2] [R3]
    wire cnv_rise = ~cnv_prev_r & cnv_sync_r; // [R1]

    // Floating select wins over a high reading from the pad sensor
    adc_readout_pkg::io_mode_t io_mode;
    assign io_mode = strap_sync_r.sel_float ? adc_readout_pkg::IO_LVDS_LOW_POWER :
                     strap_sync_r.sel_high ? adc_readout_pkg::IO_LVDS :
                     adc_readout_pkg::IO_CMOS; // [R8]
    wire lvds_sel = (io_mode != adc_readout_pkg::IO_CMOS); // [R8]

    // ------------------------------------------------------------------
    // Phase machine: acquisition while start is high, conversion while low
    // ------------------------------------------------------------------
    adc_readout_pkg::phase_t phase_r;
    adc_readout_pkg::phase_t phase_nxt;

    always_comb begin
        phase_nxt = phase_r;
        case (phase_r)
            adc_readout_pkg::PH_ACQUIRE: begin
                if (cnv_fall) begin
                    phase_nxt = adc_readout_pkg::PH_CONVERT; // [R2]
                end
            end
            adc_readout_pkg::PH_CONVERT: begin
                if (cnv_rise) begin
                    phase_nxt = adc_readout_pkg::PH_ACQUIRE; // [R1]
                end
            end
            default: begin
                phase_nxt = adc_readout_pkg::PH_ACQUIRE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= adc_readout_pkg::PH_ACQUIRE;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    wire converting = (phase_nxt == adc_readout_pkg::PH_CONVERT);

    // Outputs are released during acquisition and driven during readout
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            serial_out_oe <= 1'b0;
            diff_out_oe <= 1'b0;
        end else begin
            serial_out_oe <= converting & ~lvds_sel; // [R2] [R9]
            diff_out_oe <= converting & lvds_sel; // [R2] [R13]
        end
    end

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    logic [13:0] result_r [adc_readout_pkg::NUM_CH];
    logic [13:0] snap_r [adc_readout_pkg::NUM_CH];
    logic [15:0] conv_count_r;

    wire [7:0] bank_addr = address & adc_readout_pkg::BANK_MASK;
    wire [2:0] ch_sel = address[adc_readout_pkg::CH_SEL_LSB +: adc_readout_pkg::CH_IDX_W];
    wire hit_result = (bank_addr == adc_readout_pkg::RESULT_BASE_OFS);
    wire hit_snap = (bank_addr == adc_readout_pkg::SNAP_BASE_OFS);
    wire hit_status = (address == adc_readout_pkg::STATUS_OFS);
    wire hit_count = (address == adc_readout_pkg::CONV_COUNT_OFS);

    adc_readout_pkg::status_t status;
    assign status = '{io_mode: io_mode, echo_off: strap_sync_r.echo_off, ddr: strap_sync_r.ddr,
                      acquiring: (phase_r == adc_readout_pkg::PH_ACQUIRE)};

    wire [31:0] read_mux = hit_result ? {18'h00000, result_r[ch_sel]} :
                           hit_snap ? {18'h00000, snap_r[ch_sel]} :
                           hit_status ? {27'h0000000, status} :
                           hit_count ? {16'h0000, conv_count_r} :
                           adc_readout_pkg::READ_DATA_RST;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            read_data <= adc_readout_pkg::READ_DATA_RST;
        end else if (read_strobe) begin
            read_data <= read_mux;
        end else begin
            read_data <= adc_readout_pkg::READ_DATA_RST;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            conv_count_r <= adc_readout_pkg::CONV_COUNT_RST;
        end else if (cnv_fall) begin
            conv_count_r <= conv_count_r + 16'h0001;
        end
    end

    // Result words held in two's complement; the snapshot is frozen at start
    genvar g;
    generate
        for (g = 0; g < adc_readout_pkg::NUM_CH; g++) begin : g_ch
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    result_r[g] <= adc_readout_pkg::RESULT_RST;
                end else if (write_strobe && hit_result && ch_sel == 3'(g)) begin
                    result_r[g] <= write_data[adc_readout_pkg::RESULT_W-1:0]; // [R16]
                end
            end
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    snap_r[g] <= adc_readout_pkg::RESULT_RST;
                end else if (cnv_fall) begin
                    snap_r[g] <= result_r[g]; // [R1] [R2]
                end
            end
        end
    endgenerate

    // Rate strap is taken through the pin synchroniser and frozen with the
    // snapshot, so the link side sees a settled value for the whole frame
    // and a strap that moves mid-frame cannot change the slot arithmetic.
    logic ddr_frame_r;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ddr_frame_r <= 1'b0;
        end else if (cnv_fall) begin
            ddr_frame_r <= strap_sync_r.ddr; // [R4] [R5]
        end
    end

    // ------------------------------------------------------------------
    // Link clock domain: edge counters
    // ------------------------------------------------------------------
    // The counters are cleared while start is high, so each frame begins with
    // the first bit already on the outputs and needs no link edge to load.
    // The snapshot and the frozen rate are written only at start and are stable
    // long before the receiver may clock, so the link side reads them as static words.
    wire link_clear_n = reset_n & ~conversion_start_n; // [R1]
    logic [6:0] neg_count_r;
    logic [6:0] pos_count_r;

    // Falling edges shift in both rates
    always_ff @(negedge shift_clock or negedge link_clear_n) begin
        if (!link_clear_n) begin
            neg_count_r <= adc_readout_pkg::EDGE_CNT_RST;
        end else begin
            neg_count_r <= neg_count_r + 7'h01; // [R4] [R5]
        end
    end

    // Rising edges count only in double rate; the rate is frozen per frame,
    // so a strap change between frames takes effect at the next start
    always_ff @(posedge shift_clock or negedge link_clear_n) begin
        if (!link_clear_n) begin
            pos_count_r <= adc_readout_pkg::EDGE_CNT_RST;
        end else if (ddr_frame_r) begin
            pos_count_r <= pos_count_r + 7'h01; // [R5]
        end
    end

    // Modulo 128 = eight 16-edge slots, so the stream wraps to its start
    wire [6:0] edge_count = neg_count_r + (ddr_frame_r ? pos_count_r : 7'h00); // [R4] [R5] [R12]
    wire [2:0] slot_idx = edge_count[6:4]; // [R10] [R11] [R14]
    wire [3:0] bit_idx = 4'hF - edge_count[3:0]; // [R9]

    logic [7:0] cmos_bits;
    logic [3:0] pair_bits;

    // Each output picks its bit straight from the snapshot, so there is no
    // shift register to reload and a cut frame restarts cleanly at zero
    generate
        for (g = 0; g < adc_readout_pkg::NUM_CH; g++) begin : g_out
            wire [2:0] cmos_ch = 3'(g) + slot_idx; // [R12]
            wire [15:0] cmos_slot = {snap_r[cmos_ch], adc_readout_pkg::SLOT_PAD}; // [R9] [R16]
            assign cmos_bits[g] = cmos_slot[bit_idx]; // [R9]
            if (g < adc_readout_pkg::NUM_PAIRS) begin : g_pair
                wire [2:0] pair_ch = 3'(2 * g) + slot_idx; // [R12]
                wire [15:0] pair_slot = {snap_r[pair_ch], adc_readout_pkg::SLOT_PAD}; // [R16]
                assign pair_bits[g] = pair_slot[bit_idx]; // [R13] [R15]
            end
        end
    endgenerate

    // CMOS lanes carry their own channel, each LVDS pair a channel pair;
    // the _n leg is always the complement of the _p leg
    assign serial_out_ch1 = cmos_bits[0];
    assign serial_out_ch2 = cmos_bits[1];
    assign serial_out_ch3 = cmos_bits[2];
    assign serial_out_ch4 = cmos_bits[3];
    assign serial_out_ch5 = cmos_bits[4];
    assign serial_out_ch6 = cmos_bits[5];
    assign serial_out_ch7 = cmos_bits[6];
    assign serial_out_ch8 = cmos_bits[7];
    assign diff_out_pair_ch1_2_p = pair_bits[0];
    assign diff_out_pair_ch1_2_n = ~pair_bits[0];
    assign diff_out_pair_ch3_4_p = pair_bits[1];
    assign diff_out_pair_ch3_4_n = ~pair_bits[1];
    assign diff_out_pair_ch5_6_p = pair_bits[2];
    assign diff_out_pair_ch5_6_n = ~pair_bits[2];
    assign diff_out_pair_ch7_8_p = pair_bits[3];
    assign diff_out_pair_ch7_8_n = ~pair_bits[3];

    // Gate delay is the only skew; the receiver latches on this copy
    assign echoed_shift_clock = shift_clock & ~echo_clock_disable; // [R6] [R7] [R17]

endmodule

`default_nettype wire

// file: src/adc_readout_pkg.sv
`default_nettype none

package adc_readout_pkg;

    // Converter geometry
    localparam int NUM_CH = 8;
    localparam int NUM_PAIRS = 4;
    localparam int RESULT_W = 14;
    localparam int SLOT_W = 16;
    localparam int SLOT_BITS_W = 4;
    localparam int CH_IDX_W = 3;
    localparam int EDGE_CNT_W = 7;
    localparam logic [1:0] SLOT_PAD = 2'h0;

    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] RESULT_BASE_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h20;
    localparam logic [7:0] CONV_COUNT_OFS = 8'h24;
    localparam logic [7:0] SNAP_BASE_OFS = 8'h40;
    localparam logic [7:0] BANK_MASK = 8'hE3;
    localparam logic [2:0] CH_SEL_LSB = 3'h2;

    // Reset values
    localparam logic [13:0] RESULT_RST = 14'h0000;
    localparam logic [15:0] CONV_COUNT_RST = 16'h0000;
    localparam logic [31:0] READ_DATA_RST = 32'h00000000;
    localparam logic [6:0] EDGE_CNT_RST = 7'h00;
    localparam logic [3:0] STRAP_RST = 4'h0;

    typedef enum logic [1:0] {
        IO_CMOS,
        IO_LVDS,
        IO_LVDS_LOW_POWER
    } io_mode_t;

    typedef enum logic {
        PH_ACQUIRE,
        PH_CONVERT
    } phase_t;

    // Strap pins as sampled: {float, high, echo_off, ddr}
    typedef struct packed {
        logic sel_float;
        logic sel_high;
        logic echo_off;
        logic ddr;
    } strap_t;

    // Status word, low bits of the status register
    typedef struct packed {
        io_mode_t io_mode;
        logic echo_off;
        logic ddr;
        logic acquiring;
    } status_t;

    localparam int STATUS_W = 5;

endpackage

`default_nettype wire

// file: testbench/octal_adc_serial_readout_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module octal_adc_serial_readout_asserts (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] address,
    input wire logic read_strobe,
    input wire logic [31:0] read_data,
    input wire logic conversion_start_n,
    input wire logic shift_clock,
    input wire logic data_rate_select,
    input wire logic echo_clock_disable,
    input wire logic io_select_high,
    input wire logic io_select_float,
    input wire logic echoed_shift_clock,
    input wire logic serial_out_oe,
    input wire logic diff_out_oe,
    input wire logic diff_out_pair_ch1_2_p,
    input wire logic diff_out_pair_ch1_2_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    wire logic lvds = io_select_high | io_select_float;

    AST_ECHO_COPY: assert property (echoed_shift_clock == (shift_clock & !echo_clock_disable))
        else $error("echo clock mismatch");
    AST_ACQ_IDLE: assert property (conversion_start_n [*5] |-> !serial_out_oe && !diff_out_oe)
        else $error("outputs enabled in acquisition");
    AST_CMOS_ON: assert property ((!conversion_start_n && !lvds) [*6] |-> serial_out_oe && !diff_out_oe)
        else $error("cmos enables wrong");
    AST_LVDS_ON: assert property ((!conversion_start_n && lvds) [*6] |-> diff_out_oe && !serial_out_oe)
        else $error("lvds enables wrong");
    AST_START_OE: assert property ($fell(conversion_start_n) |-> ##[1:4] $rose(serial_out_oe | diff_out_oe))
        else $error("no output after start");
    AST_PAIR_POLARITY: assert property (diff_out_pair_ch1_2_n == !diff_out_pair_ch1_2_p)
        else $error("pair not complementary");
    AST_RESULT_BITS: assert property ($past(read_strobe) && $past(address) < adc_readout_pkg::STATUS_OFS
        |-> read_data[31:14] == 18'h0) else $error("result upper bits set");
    AST_STATUS_STRAPS: assert property ($past(read_strobe) && $past(address) == adc_readout_pkg::STATUS_OFS
        |-> read_data[4:1] == {io_select_float ? 2'h2 : {1'h0, io_select_high}, echo_clock_disable,
        data_rate_select}) else $error("status straps wrong");

    cover property ($fell(conversion_start_n) && lvds);
    cover property ($rose(serial_out_oe));
    cover property ($past(read_strobe) && $past(address) == adc_readout_pkg::STATUS_OFS);
endmodule

`default_nettype wire

// file: testbench/sample_clock_receiver.sv
`timescale 1ns/10ps
`default_nettype none

module sample_clock_receiver (
    input wire logic ddr,
    output logic shift_clock,
    output logic conversion_start_n,
    output logic tick
);
    initial begin
        shift_clock = 1'h0;
        conversion_start_n = 1'h1;
        tick = 1'h0;
    end

    // Clock stands low between frames; tick marks a settled bit
    task automatic frame(input int n);
        conversion_start_n <= 1'h0;
        #600;
        repeat (n) begin
            tick <= !tick;
            #14;
            if (!ddr) begin
                shift_clock <= 1'h1;
                #24;
            end
            shift_clock <= !shift_clock;
            #10;
        end
        #20;
        conversion_start_n <= 1'h1;
        #1000;
    endtask
endmodule

`default_nettype wire

// file: testbench/tb_octal_adc_serial_readout.sv
`timescale 1ns/10ps
`default_nettype none

module tb_octal_adc_serial_readout;
    logic clock, reset_n, write_strobe, read_strobe, data_rate_select, echo_clock_disable;
    logic io_select_high, io_select_float, lv;
    logic rd_d = 1'h0;
    logic [7:0] address;
    logic [31:0] write_data, seed;
    logic [13:0] res [8];
    logic [31:0] rq [$];
    logic [31:0] sq [$];
    int fails, samples_checked;
    wire [31:0] read_data;
    wire [7:0] sd;
    wire [3:0] dp, dn;
    wire shift_clock, conversion_start_n, tick, echoed_shift_clock, serial_out_oe, diff_out_oe;

    octal_adc_serial_readout uut (
        .clock, .reset_n, .address, .write_data, .write_strobe, .read_strobe, .read_data,
        .conversion_start_n, .shift_clock, .data_rate_select, .echo_clock_disable,
        .io_select_high, .io_select_float, .echoed_shift_clock, .serial_out_oe, .diff_out_oe,
        .serial_out_ch1(sd[0]), .serial_out_ch2(sd[1]), .serial_out_ch3(sd[2]), .serial_out_ch4(sd[3]),
        .serial_out_ch5(sd[4]), .serial_out_ch6(sd[5]), .serial_out_ch7(sd[6]), .serial_out_ch8(sd[7]),
        .diff_out_pair_ch1_2_p(dp[0]), .diff_out_pair_ch1_2_n(dn[0]), .diff_out_pair_ch3_4_p(dp[1]),
        .diff_out_pair_ch3_4_n(dn[1]), .diff_out_pair_ch5_6_p(dp[2]), .diff_out_pair_ch5_6_n(dn[2]),
        .diff_out_pair_ch7_8_p(dp[3]), .diff_out_pair_ch7_8_n(dn[3])
    );

    sample_clock_receiver rx (.ddr(data_rate_select), .shift_clock, .conversion_start_n, .tick);

    initial begin
        clock = 1'h0;
        forever #50 clock = !clock;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Bit seen after i shifting edges; lanes 0-3 of a pair word repeat as 4-7
    function automatic logic [7:0] ex(input int i, input logic l);
        logic [15:0] s;
        int c;
        for (int k = 0; k < 8; k++) begin
            c = l ? (2 * (k % 4) + i / 16) % 8 : (k + i / 16) % 8;
            s = {res[c], 2'h0};
            ex[k] = s[15 - i % 16];
        end
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        if (!w)
            rq.push_back(d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= w;
        read_strobe <= !w;
        @(posedge clock);
        write_strobe <= 1'h0;
        read_strobe <= 1'h0;
    endtask

    task automatic results;
        $display("compared %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clock) begin
        if (rd_d)
            check(read_data, rq.pop_front());
        rd_d <= read_strobe;
    end

    always @(tick) begin
        if (sq.size() > 0)
            check({24'h0, lv ? {~dn, dp} : sd}, sq.pop_front());
    end

    initial begin
        #1000000;
        fails++;
        results();
    end

    initial begin
        {write_strobe, read_strobe, data_rate_select, echo_clock_disable} = 4'h0;
        {io_select_high, io_select_float, lv} = 3'h0;
        address = 8'h00;
        write_data = 32'h0;
        reset_n = 1'h0;
        seed = 32'h84DE;
        repeat (3) @(posedge clock);
        reset_n <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            res[i] = i == 0 ? 14'h2000 : i == 7 ? 14'h1FFF : seed[13:0];
            bus(1'h1, 8'(4 * i), {seed[31:14], res[i]});
        end
        for (int i = 0; i < 8; i++)
            bus(1'h0, 8'(4 * i), {18'h0, res[i]});
        bus(1'h0, 8'h3C, 32'h0);
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            @(posedge clock);
            io_select_high <= m == 2;
            io_select_float <= m == 3;
            data_rate_select <= m[0];
            echo_clock_disable <= m == 3;
            lv = m[1];
            repeat (2) @(posedge clock);
            bus(1'h0, adc_readout_pkg::STATUS_OFS, {27'h0, m[1] ? 2'(m - 1) : 2'h0, m == 3, m[0], 1'h1});
            for (int i = 0; i < (m == 0 ? 144 : 40); i++)
                sq.push_back({24'h0, ex(i, lv)});
            rx.frame(m == 0 ? 144 : 40);
            $display("test frame %0d done", m);
        end
        bus(1'h1, adc_readout_pkg::SNAP_BASE_OFS, 32'h0);
        bus(1'h0, adc_readout_pkg::SNAP_BASE_OFS, {18'h0, res[0]});
        bus(1'h0, adc_readout_pkg::CONV_COUNT_OFS, 32'h4);
        repeat (2) @(posedge clock);
        check(32'(sq.size() + rq.size()), 32'h0);
        $display("test readback done");
        results();
    end
endmodule

bind octal_adc_serial_readout octal_adc_serial_readout_asserts chk (
    .clock, .reset_n, .address, .read_strobe, .read_data, .conversion_start_n, .shift_clock,
    .data_rate_select, .echo_clock_disable, .io_select_high, .io_select_float, .echoed_shift_clock,
    .serial_out_oe, .diff_out_oe, .diff_out_pair_ch1_2_p, .diff_out_pair_ch1_2_n
);

`default_nettype wire
